// ---- rtl/lamc_top.sv ----
`include "lamc_params.svh"
module lamc_top (
	input  wire logic               I_CLK,
	input  wire logic               I_SYS_RST,
	input  wire logic               I_EXEC_EN,
	input  wire lamc_pkg::lamc_cmd_s I_CMD,
	input  wire logic signed [31:0] I_FIRST_SOURCE,
	input  wire logic signed [31:0] I_SECOND_SOURCE,
	input  wire logic               I_PREV_CONTACT,
	input  wire logic               I_ERR_CLEAR,
	output lamc_pkg::lamc_res_s     O_RESULT,
	output logic                    O_CONTACT,
	output logic                    O_ERROR_FLAG_PRIMARY,
	output logic                    O_ERROR_FLAG_LATCHED,
	output logic [15:0]             O_HELD_WORD
);
	// ------------------------------
	// Execution condition
	// ------------------------------
	// Edge detector resets low, the idle level, so no false pulse follows reset
	logic en_d;
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) en_d <= 1'b0;
		else           en_d <= I_EXEC_EN;
	end
	// plain each scan, pulse on edge
	wire fire_w = I_CMD.pulse ? (I_EXEC_EN && !en_d) : I_EXEC_EN;

	// ------------------------------
	// Arithmetic
	// ------------------------------
	// Upper source halves are ignored by arithmetic and copy
	// sources as signed 16-bit
	wire signed [15:0] a16 = I_FIRST_SOURCE[15:0];
	wire signed [15:0] b16 = I_SECOND_SOURCE[15:0];
	// signs from bit 15, product bit 31
	wire signed [31:0] prod_w = a16 * b16;
	// Overflow case -32768 / -1 wraps to -32768; no error is raised for it
	wire signed [15:0] quot_w = (b16 == `LAMC_ZERO16) ? `LAMC_ZERO16 : 16'(a16 / b16);
	wire signed [15:0] rem_w = (b16 == `LAMC_ZERO16) ? `LAMC_ZERO16 : 16'(a16 % b16);
	wire is_mul  = I_CMD.op == lamc_pkg::LAMC_OP_MUL;
	wire is_div  = I_CMD.op == lamc_pkg::LAMC_OP_DIV;
	wire is_move = I_CMD.op == lamc_pkg::LAMC_OP_MOVE;
	wire arith_w = is_mul || is_div;
	wire div0_w = is_div && (b16 == `LAMC_ZERO16);
	wire idx_w  = arith_w && I_CMD.tgt_index;
	wire err_w  = fire_w && (div0_w || idx_w);

	// ------------------------------
	// Target width mask
	// ------------------------------
	// nibble count from bit 0
	logic [31:0] bitmask_w;
	genvar gi;
	generate
		for (gi = 0; gi < `LAMC_W32; gi = gi + 1) begin : g_mask
			assign bitmask_w[gi] = (gi / `LAMC_NIB_W) < 32'(I_CMD.nibbles);
		end
	endgenerate
	wire [31:0] div_word_w = {rem_w, quot_w};
	wire [31:0] raw_w = is_mul ? prod_w : is_div ? div_word_w : {`LAMC_ZERO16, I_FIRST_SOURCE[15:0]};
	// Word targets: product is 32 bits, copy only 16
	wire [31:0] wmask_w     = is_mul ? `LAMC_MASK32 : `LAMC_MASK16;
	// bit target gets quotient only
	// Remainder never reaches bit targets, even with more nibbles
	wire [31:0] div_bmask_w = bitmask_w & `LAMC_MASK16;
	wire [31:0] bit_mask_w  = is_div ? div_bmask_w : (bitmask_w & wmask_w);
	wire [31:0] word_mask_w = is_div ? `LAMC_MASK32 : wmask_w;
	wire [31:0] mask_w      = I_CMD.tgt_bits ? bit_mask_w : word_mask_w;
	wire do_write_w = fire_w && (arith_w || is_move) && !err_w;

	// ------------------------------
	// Result and flags
	// ------------------------------
	// Mask tells the engine which target bits to overwrite
	logic [15:0] held;
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_RESULT <= '0;
		end else begin
			O_RESULT.valid <= do_write_w;
			O_RESULT.data  <= do_write_w ? (raw_w & mask_w) : `LAMC_ZERO32;
			O_RESULT.mask  <= do_write_w ? mask_w : `LAMC_ZERO32;
		end
	end
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST)                   held <= `LAMC_ZERO16;
		else if (do_write_w && is_move)  held <= I_FIRST_SOURCE[15:0];
	end
	assign O_HELD_WORD = held;
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_ERROR_FLAG_PRIMARY <= 1'b0;
			O_ERROR_FLAG_LATCHED <= 1'b0;
		end else begin
			O_ERROR_FLAG_PRIMARY <= err_w;
			// Set wins over clear
			O_ERROR_FLAG_LATCHED <= err_w || (O_ERROR_FLAG_LATCHED && !I_ERR_CLEAR);
		end
	end

	// ------------------------------
	// Comparison contact
	// ------------------------------
	lamc_compare32 i_lamc_compare32 (
		.i_clk          (I_CLK),
		.i_rst          (I_SYS_RST),
		.i_first_source (I_FIRST_SOURCE),
		.i_second_source(I_SECOND_SOURCE),
		.i_rel          (I_CMD.rel),
		.i_form         (I_CMD.form),
		.i_prev         (I_PREV_CONTACT),
		.o_contact      (O_CONTACT)
	);

	// ------------------------------
	// Checks
	// ------------------------------
	AST_MUL: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(fire_w && is_mul && !I_CMD.tgt_bits && !I_CMD.tgt_index) |=> O_RESULT.valid
		&& O_RESULT.data == 32'($signed($past(I_FIRST_SOURCE[15:0])) * $signed($past(I_SECOND_SOURCE[15:0]))))
		else $error("product wrong");
	AST_DIV0: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(fire_w && is_div && b16 == `LAMC_ZERO16) |=> O_ERROR_FLAG_PRIMARY && O_ERROR_FLAG_LATCHED)
		else $error("zero divisor not flagged");
	AST_IDX: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(fire_w && arith_w && I_CMD.tgt_index) |=> O_ERROR_FLAG_PRIMARY)
		else $error("index target not flagged");
	AST_NOWR: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		err_w |=> !O_RESULT.valid)
		else $error("write on error");
	AST_DIVW: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(do_write_w && is_div && !I_CMD.tgt_bits)
		|=> O_RESULT.data[15:0]
		== 16'($signed($past(I_FIRST_SOURCE[15:0])) / $signed($past(I_SECOND_SOURCE[15:0])))
		&& O_RESULT.data[31:16]
		== 16'($signed($past(I_FIRST_SOURCE[15:0])) % $signed($past(I_SECOND_SOURCE[15:0]))))
		else $error("divide layout wrong");
	AST_BITS: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(do_write_w && I_CMD.tgt_bits && I_CMD.nibbles == `LAMC_NIB_ONE) |=> O_RESULT.mask == `LAMC_MASK_NIB1)
		else $error("nibble mask wrong");
	AST_MOVE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(do_write_w && is_move) |=> O_HELD_WORD == $past(I_FIRST_SOURCE[15:0]))
		else $error("copy wrong");
	AST_HOLD: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		!(do_write_w && is_move) |=> $stable(O_HELD_WORD))
		else $error("held word changed");
	AST_PULSE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_CMD.pulse && en_d && I_EXEC_EN && !err_w) |=> !O_RESULT.valid)
		else $error("pulse form repeated");
	AST_SERIES: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_CMD.form == lamc_pkg::LAMC_FORM_SERIES && !I_PREV_CONTACT) |=> !O_CONTACT)
		else $error("series contact on without predecessor");
	AST_SIGN: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_CMD.form == lamc_pkg::LAMC_FORM_LOAD && I_CMD.rel == lamc_pkg::LAMC_REL_LT
		&& I_FIRST_SOURCE[31] && !I_SECOND_SOURCE[31]) |=> O_CONTACT)
		else $error("negative not less");

	// ------------------------------
	// Checks on results, flags and contact
	// ------------------------------
	AST_MULSGN: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(fire_w && is_mul && !I_CMD.tgt_bits && !I_CMD.tgt_index
		&& I_FIRST_SOURCE[15:0] != `LAMC_ZERO16 && I_SECOND_SOURCE[15:0] != `LAMC_ZERO16)
		|=> O_RESULT.data[31] == ($past(I_FIRST_SOURCE[15]) ^ $past(I_SECOND_SOURCE[15])))
		else $error("product sign wrong");
	AST_RANGE: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(fire_w && is_mul && !I_CMD.tgt_bits && !I_CMD.tgt_index)
		|=> $signed(O_RESULT.data) <= $signed(`LAMC_PROD_MAX)
		&& $signed(O_RESULT.data) >= $signed(`LAMC_PROD_MIN))
		else $error("product outside signed range");
	AST_DIVBIT: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(do_write_w && is_div && I_CMD.tgt_bits)
		|=> O_RESULT.mask[31:16] == `LAMC_ZERO16 && O_RESULT.data[31:16] == `LAMC_ZERO16)
		else $error("remainder reached bit target");
	AST_REMSGN: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(do_write_w && is_div && !I_CMD.tgt_bits)
		|=> O_RESULT.data[31:16] == `LAMC_ZERO16 || O_RESULT.data[31] == $past(I_FIRST_SOURCE[15]))
		else $error("remainder sign wrong");
	AST_MOVEW: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(do_write_w && is_move && !I_CMD.tgt_bits)
		|=> O_RESULT.mask == `LAMC_MASK16 && O_RESULT.data == {`LAMC_ZERO16, $past(I_FIRST_SOURCE[15:0])})
		else $error("word copy wrong");
	AST_NIBMAX: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(do_write_w && I_CMD.tgt_bits && I_CMD.nibbles == `LAMC_NIB_MAX)
		|=> O_RESULT.mask == `LAMC_MASK16)
		else $error("four nibble mask wrong");
	AST_PLAIN: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(!I_CMD.pulse && I_EXEC_EN && (arith_w || is_move) && !err_w)
		|=> O_RESULT.valid)
		else $error("plain form skipped a scan");
	AST_CMPNW: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_CMD.op == lamc_pkg::LAMC_OP_CMP)
		|=> !O_RESULT.valid)
		else $error("comparison wrote a result");
	AST_PAR: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_CMD.form == lamc_pkg::LAMC_FORM_PARALLEL && I_PREV_CONTACT)
		|=> O_CONTACT)
		else $error("parallel contact dropped predecessor");
	AST_DIVOK: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(fire_w && is_div && b16 != `LAMC_ZERO16 && !I_CMD.tgt_index)
		|=> !O_ERROR_FLAG_PRIMARY)
		else $error("error on legal divide");
	AST_STICKY: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(O_ERROR_FLAG_LATCHED && !I_ERR_CLEAR)
		|=> O_ERROR_FLAG_LATCHED)
		else $error("latched error lost");
	AST_CLR: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_ERR_CLEAR && !err_w)
		|=> !O_ERROR_FLAG_LATCHED)
		else $error("latched error not cleared");
	AST_IDXW: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		(fire_w && arith_w && I_CMD.tgt_index)
		|=> !O_RESULT.valid)
		else $error("index target written");
endmodule

// ---- common/lamc_params.svh ----
// Notes on behaviour
// - Multiply writes the signed product of the first and second source to the target.
// - Multiply and divide sources are signed 16-bit values from -32768 to 32767.
// - Source signs come from bit 15 and the 32-bit product carries its sign in bit 31.
// - A bit-device target takes only the designated nibble count of bits from bit 0 upward.
// - Divide writes quotient and remainder as 32 bits to a word target, only the 16-bit quotient to a bit target.
// - The quotient sits in the lower 16 bits and the remainder in the upper 16 bits.
// - Divide is signed and quotient and remainder each carry their sign in bit 15 of their own word.
// - A zero divisor raises an operation error and sets the error flag.
// - Multiply or divide aimed at an index register is an operation error with the error flag set.
// - Word copy moves all 16 source bits unchanged to the target.
// - A copied value stays in its target until a later transfer writes there.
// - A 32-bit comparison is a contact that turns on while its relation holds, or in the parallel form while the preceding contact is on.
// - Six relations in load, series and parallel forms give 18 comparison variants.
// - Comparison operands are signed two's complement, so bit 31 set means negative.
// - The series form is evaluated only while the preceding contact is on; the others every scan.
`ifndef LAMC_PARAMS_SVH
`define LAMC_PARAMS_SVH
`define LAMC_W16        16
`define LAMC_W32        32
`define LAMC_NIB_W      4
`define LAMC_NIB_MAX    3'h4
`define LAMC_NIB_MAX32  4'h8
`define LAMC_ZERO16     16'h0000
`define LAMC_ZERO32     32'h0000_0000
`define LAMC_MASK16     32'h0000_FFFF
`define LAMC_MASK32     32'hFFFF_FFFF
`define LAMC_NIB_ONE    3'h1
`define LAMC_MASK_NIB1  32'h0000_000F
`define LAMC_PROD_MAX   32'h4000_0000
`define LAMC_PROD_MIN   32'hC000_8000
`endif

// ---- common/lamc_pkg.sv ----
package lamc_pkg;
	typedef enum logic [1:0] {
		LAMC_OP_MUL,
		LAMC_OP_DIV,
		LAMC_OP_MOVE,
		LAMC_OP_CMP
	} lamc_op_e;
	typedef enum logic [2:0] {
		LAMC_REL_EQ,
		LAMC_REL_NE,
		LAMC_REL_GT,
		LAMC_REL_LE,
		LAMC_REL_LT,
		LAMC_REL_GE
	} lamc_rel_e;
	typedef enum logic [1:0] {
		LAMC_FORM_LOAD,
		LAMC_FORM_SERIES,
		LAMC_FORM_PARALLEL
	} lamc_form_e;
	typedef struct packed {
		lamc_op_e    op;
		logic        pulse;
		lamc_rel_e   rel;
		lamc_form_e  form;
		logic        tgt_bits;
		logic        tgt_index;
		logic [2:0]  nibbles;
	} lamc_cmd_s;
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
		logic [31:0] mask;
	} lamc_res_s;
endpackage

// ---- rtl/lamc_compare32.sv ----
`include "lamc_params.svh"
module lamc_compare32 (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic signed [31:0]   i_first_source,
	input  wire logic signed [31:0]   i_second_source,
	input  wire lamc_pkg::lamc_rel_e  i_rel,
	input  wire lamc_pkg::lamc_form_e i_form,
	input  wire logic                 i_prev,
	output logic                      o_contact
);
	// ------------------------------
	// Relation select
	// ------------------------------
	// signed operand compare
	wire eq_w = i_first_source == i_second_source;
	wire lt_w = i_first_source < i_second_source;
	logic rel_w;
	always_comb begin
		unique case (i_rel)
			lamc_pkg::LAMC_REL_EQ: rel_w = eq_w;
			lamc_pkg::LAMC_REL_NE: rel_w = !eq_w;
			lamc_pkg::LAMC_REL_GT: rel_w = !eq_w && !lt_w;
			lamc_pkg::LAMC_REL_LE: rel_w = eq_w || lt_w;
			lamc_pkg::LAMC_REL_LT: rel_w = lt_w;
			lamc_pkg::LAMC_REL_GE: rel_w = !lt_w;
			default:               rel_w = 1'b0;
		endcase
	end
	wire series_w = i_form == lamc_pkg::LAMC_FORM_SERIES;
	wire par_w    = i_form == lamc_pkg::LAMC_FORM_PARALLEL;
	// load follows relation; series ANDs, parallel ORs it with predecessor
	wire next_contact = series_w ? (i_prev && rel_w) : par_w ? (i_prev || rel_w) : rel_w;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) o_contact <= 1'b0;
		else       o_contact <= next_contact;
	end
endmodule

// ---- sim/lamc_scan_model.sv ----
module lamc_scan_model (
	input  wire logic           i_clk,
	output logic                o_en,
	output lamc_pkg::lamc_cmd_s o_cmd,
	output logic signed [31:0]  o_a,
	output logic signed [31:0]  o_b,
	output logic                o_prev,
	output logic                o_clr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_en = 1'b0;
		o_cmd = '0;
		o_a = 32'h0000_0000;
		o_b = 32'h0000_0000;
		o_prev = 1'b0;
		o_clr = 1'b0;
	end
	task automatic put(input lamc_pkg::lamc_cmd_s c, input int a, input int b, input logic en, input logic p,
		input logic clr);
		@(posedge i_clk);
		#1;
		o_cmd = c;
		// Idle operands flip so a stale value never passes for a live one
		o_a = en ? a : ~o_a;
		o_b = en ? b : ~o_b;
		o_en = en;
		o_prev = p;
		o_clr = clr;
	endtask
endmodule

// ---- sim/tb_ladder_arith_move_compare.sv ----
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin err_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_ladder_arith_move_compare;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clk;
	logic                rst;
	logic                en;
	logic                prev;
	logic                clr;
	logic signed [31:0]  a;
	logic signed [31:0]  b;
	lamc_pkg::lamc_cmd_s cmd;
	lamc_pkg::lamc_res_s res;
	logic                ct;
	logic                ep;
	logic                el;
	logic [15:0]         hw;
	int                  err_count;
	int                  n_compared;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	lamc_scan_model i_lamc_scan_model (.i_clk(clk), .o_en(en), .o_cmd(cmd), .o_a(a), .o_b(b), .o_prev(prev), .o_clr(clr));
	lamc_top i_lamc_top (.I_CLK(clk), .I_SYS_RST(rst), .I_EXEC_EN(en), .I_CMD(cmd), .I_FIRST_SOURCE(a),
		.I_SECOND_SOURCE(b), .I_PREV_CONTACT(prev), .I_ERR_CLEAR(clr), .O_RESULT(res), .O_CONTACT(ct),
		.O_ERROR_FLAG_PRIMARY(ep), .O_ERROR_FLAG_LATCHED(el), .O_HELD_WORD(hw));
	function automatic lamc_pkg::lamc_cmd_s mk(lamc_pkg::lamc_op_e o, logic p, logic bt, logic ix, logic [2:0] nb,
		lamc_pkg::lamc_rel_e r, lamc_pkg::lamc_form_e f);
		return '{o, p, r, f, bt, ix, nb};
	endfunction
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic ar(lamc_pkg::lamc_op_e o, logic bt, logic ix, logic [2:0] nb, int x, int y, logic v,
		logic [31:0] d, logic [31:0] m);
		i_lamc_scan_model.put(mk(o, 1'b0, bt, ix, nb, lamc_pkg::LAMC_REL_EQ, lamc_pkg::LAMC_FORM_LOAD), x, y, 1, 0, 0);
		@(posedge clk);
		#1;
		`CHK("valid", v, res.valid)
		`CHK("error", ~v, ep)
		if (v) begin
			`CHK("data", d, res.data)
			`CHK("mask", m, res.mask)
		end
		i_lamc_scan_model.put(cmd, 0, 0, 0, 0, 0);
	endtask
	task automatic t_err();
		ar(lamc_pkg::LAMC_OP_DIV, 0, 0, 3'h4, 5, 0, 0, 0, 0);
		`CHK("latched", 1'b1, el)
		i_lamc_scan_model.put(cmd, 0, 0, 0, 0, 1);
		@(posedge clk);
		#1;
		`CHK("cleared", 1'b0, el)
		ar(lamc_pkg::LAMC_OP_MUL, 0, 1, 3'h4, 5, 3, 0, 0, 0);
	endtask
	task automatic t_move();
		ar(lamc_pkg::LAMC_OP_MOVE, 1, 0, 3'h2, 32'h9C33, 0, 1, 32'h0000_0033, 32'h0000_00FF);
		ar(lamc_pkg::LAMC_OP_MOVE, 0, 0, 3'h4, 32'h9C33, 0, 1, 32'h0000_9C33, 32'h0000_FFFF);
		ar(lamc_pkg::LAMC_OP_MUL, 0, 0, 3'h4, 2, 2, 1, 32'h0000_0004, 32'hFFFF_FFFF);
		`CHK("held", 16'h9C33, hw)
	endtask
	task automatic t_pulse();
		i_lamc_scan_model.put(mk(lamc_pkg::LAMC_OP_MOVE, 1, 0, 0, 3'h4, lamc_pkg::LAMC_REL_EQ,
			lamc_pkg::LAMC_FORM_LOAD), 32'h1234, 0, 1, 0, 0);
		@(posedge clk);
		#1;
		`CHK("pulse first", 1'b1, res.valid)
		`CHK("pulse data", 32'h0000_1234, res.data)
		@(posedge clk);
		#1;
		`CHK("pulse again", 1'b0, res.valid)
		i_lamc_scan_model.put(cmd, 0, 0, 0, 0, 0);
		`CHK("held new", 16'h1234, hw)
	endtask
	task automatic t_cmp(int x, int y);
		logic r;
		logic e;
		for (int p = 0; p < 2; p++)
			for (int f = 0; f < 3; f++)
				for (int k = 0; k < 6; k++) begin
					case (k)
						0: r = x == y;
						1: r = x != y;
						2: r = x > y;
						3: r = x <= y;
						4: r = x < y;
						default: r = x >= y;
					endcase
					e = (f == 0) ? r : (f == 1) ? (p[0] & r) : (p[0] | r);
					i_lamc_scan_model.put(mk(lamc_pkg::LAMC_OP_CMP, 0, 0, 0, 3'h4, lamc_pkg::lamc_rel_e'(k),
						lamc_pkg::lamc_form_e'(f)), x, y, 1, p[0], 0);
					@(posedge clk);
					#1;
					`CHK("contact", e, ct)
					`CHK("no write", 1'b0, res.valid)
				end
	endtask
	initial begin
		err_count = 0;
		n_compared = 0;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		`CHK("reset valid", 1'b0, res.valid)
		`CHK("reset held", 16'h0000, hw)
		`CHK("reset flag", 1'b0, el)
		`CHK("reset contact", 1'b0, ct)
		ar(lamc_pkg::LAMC_OP_MUL, 0, 0, 3'h4, 5, -3, 1, 32'hFFFF_FFF1, 32'hFFFF_FFFF);
		ar(lamc_pkg::LAMC_OP_MUL, 0, 0, 3'h4, -32768, -32768, 1, 32'h4000_0000, 32'hFFFF_FFFF);
		ar(lamc_pkg::LAMC_OP_MUL, 0, 0, 3'h4, 32767, -32768, 1, 32'hC000_8000, 32'hFFFF_FFFF);
		ar(lamc_pkg::LAMC_OP_MUL, 1, 0, 3'h1, 5678, 1234, 1, 32'h0000_000C, 32'h0000_000F);
		ar(lamc_pkg::LAMC_OP_DIV, 0, 0, 3'h4, -5, 3, 1, 32'hFFFE_FFFF, 32'hFFFF_FFFF);
		ar(lamc_pkg::LAMC_OP_DIV, 0, 0, 3'h4, 5, -3, 1, 32'h0002_FFFF, 32'hFFFF_FFFF);
		ar(lamc_pkg::LAMC_OP_DIV, 0, 0, 3'h4, -5, -3, 1, 32'hFFFE_0001, 32'hFFFF_FFFF);
		ar(lamc_pkg::LAMC_OP_DIV, 1, 0, 3'h4, -5, 3, 1, 32'h0000_FFFF, 32'h0000_FFFF);
		t_err();
		t_move();
		t_pulse();
		t_cmp(-1, 1);
		t_cmp(32'h8000_0000, 32'h7FFF_FFFF);
		t_cmp(7, 7);
		results();
	end
	initial begin
		#1ms;
		err_count++;
		results();
	end
endmodule
